/* File: slvc_subclock_ctrl.sv */
`timescale 1ns/1ps
`include "slvc_consts.svh"
module slvc_subclock_ctrl #(
   parameter int REG_WAIT_CYC = `SLVC_REG_WAIT_CYC,
   parameter int OSC_WAIT_CYC = `SLVC_OSC_WAIT_CYC
) (
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic [31:0]               hrdata,
   input  wire logic                 devResetIn,
   output slvc_pkg::slvc_dev_wr_t    devWr,
   output logic                      serialClkEn,
   output logic                      periphStop
);
   slvc_pkg::slvc_regs_t q;
   slvc_pkg::slvc_regs_t n;
   logic                 addrPh;
   logic                 idleOk;

   function automatic logic [31:0] readMux(input logic [7:0] a,
                                           input slvc_pkg::slvc_regs_t s);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (a)
         `SLVC_OFS_STAT:  v = {27'h0, s.rstLvl, s.mode, (s.st != slvc_pkg::StIdle), s.done};
         `SLVC_OFS_CLK:   v = {24'h0, s.clkShadow};
         `SLVC_OFS_INTEN: v = {24'h0, s.intEn};
         default:         v = 32'h0000_0000;
      endcase
      return v;
   endfunction : readMux

   assign addrPh = hsel & htrans[1] & hready & q.rdy;
   // commands held off while device reset and its settle stand
   assign idleOk = (q.st == slvc_pkg::StIdle) & ~q.rstLvl;

   always_comb begin
      n = q;
      n.dev.stb = 1'b0;
      // Reset pin filter: change taken once stages two and three agree
      n.sync = {q.sync[1], q.sync[0], devResetIn};
      if (q.sync[1] == q.sync[2]) begin
         n.rstLvl = q.sync[2];
      end
      // Bus slave: reads take one wait state so hrdata comes from a flop
      n.wrPend = addrPh & hwrite;
      n.wrAddr = haddr[7:0];
      n.rdy = 1'b1;
      if (addrPh & ~hwrite) begin
         n.rdy = 1'b0;
         n.rdata = readMux(haddr[7:0], q);
      end
      if (q.wrPend) begin
         case (q.wrAddr)
            `SLVC_OFS_CTRL: begin
               if (idleOk) begin
                  if (hwdata[`SLVC_CTRL_MARK_LV]) begin
                     n.mode = slvc_pkg::ModeLvSub;
                     n.serClkEn = 1'b0;
                     // key, detector and subclock timers left running
                     n.periphStop = 1'b1;
                  end else if (hwdata[`SLVC_CTRL_REL_LV] && q.mode == slvc_pkg::ModeLvSub) begin
                     n.st = slvc_pkg::StDisInt;
                  end else if (hwdata[`SLVC_CTRL_REL_SUB] && q.mode == slvc_pkg::ModeSub) begin
                     n.st = q.clkShadow[`SLVC_CLK_OSC_BIT] ? slvc_pkg::StOscOn
                                                            : slvc_pkg::StClrSel;
                  end
               end
            end
            `SLVC_OFS_STAT: begin
               if (hwdata[`SLVC_STAT_DONE]) begin
                  n.done = 1'b0;
               end
            end
            `SLVC_OFS_CLK: begin
               if (idleOk) begin
                  n.clkShadow = hwdata[7:0];
               end
            end
            `SLVC_OFS_INTEN: begin
               n.intEn = hwdata[7:0];
            end
            default: begin
            end
         endcase
      end
      // single-cycle strobes only, no waited accesses
      case (q.st)
         slvc_pkg::StIdle: begin
         end
         slvc_pkg::StDisInt: begin
            n.dev = '{1'b1, `SLVC_DEV_INTCTL, `SLVC_INT_OFF};
            n.st = slvc_pkg::StProtEn;
         end
         slvc_pkg::StProtEn: begin
            // open protection just before level write
            n.dev = '{1'b1, `SLVC_DEV_PROT, `SLVC_PROT_ENABLE};
            n.st = slvc_pkg::StLevel;
         end
         slvc_pkg::StLevel: begin
            n.dev = '{1'b1, `SLVC_DEV_LEVEL, `SLVC_LEVEL_SUB};
            n.st = slvc_pkg::StProtOff;
         end
         slvc_pkg::StProtOff: begin
            n.dev = '{1'b1, `SLVC_DEV_PROT, `SLVC_PROT_LOCK};
            n.mode = slvc_pkg::ModeSub;
            n.cnt = `SLVC_CNT_W'(REG_WAIT_CYC - 1);
            n.st = slvc_pkg::StRegWait;
         end
         slvc_pkg::StRegWait: begin
            if (q.cnt == '0) begin
               n.st = slvc_pkg::StRestore;
            end else begin
               n.cnt = q.cnt - `SLVC_CNT_W'(1);
            end
         end
         slvc_pkg::StRestore: begin
            n.dev = '{1'b1, `SLVC_DEV_INTCTL, q.intEn};
            n.periphStop = 1'b0;
            n.serClkEn = 1'b1;
            n.done = 1'b1;
            n.st = slvc_pkg::StIdle;
         end
         slvc_pkg::StOscOn: begin
            // PLL left off, only the oscillator restarts
            n.clkShadow[`SLVC_CLK_OSC_BIT] = 1'b0;
            n.dev = '{1'b1, `SLVC_DEV_CLOCK, n.clkShadow};
            n.cnt = `SLVC_CNT_W'(OSC_WAIT_CYC - 1);
            n.st = slvc_pkg::StOscWait;
         end
         slvc_pkg::StOscWait: begin
            if (q.cnt == '0) begin
               n.st = slvc_pkg::StClrSel;
            end else begin
               n.cnt = q.cnt - `SLVC_CNT_W'(1);
            end
         end
         slvc_pkg::StClrSel: begin
            n.clkShadow[`SLVC_CLK_SEL_BIT] = 1'b0;
            n.dev = '{1'b1, `SLVC_DEV_CLOCK, n.clkShadow};
            n.mode = slvc_pkg::ModeNormal;
            n.done = 1'b1;
            n.st = slvc_pkg::StIdle;
         end
         default: begin
            n.st = slvc_pkg::StIdle;
         end
      endcase
      if (q.rstLvl) begin
         n.st = slvc_pkg::StIdle;
         n.mode = slvc_pkg::ModeNormal;
         n.clkShadow = `SLVC_CLK_RESET;
         n.dev.stb = 1'b0;
         n.serClkEn = 1'b1;
         n.periphStop = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '{st: slvc_pkg::StIdle, mode: slvc_pkg::ModeNormal, serClkEn: 1'b1,
                rdy: 1'b1, default: '0};
      end else begin
         q <= n;
      end
   end

   assign hreadyout   = q.rdy;
   assign hresp       = 1'b0;
   assign hrdata      = q.rdata;
   assign devWr       = q.dev;
   assign serialClkEn = q.serClkEn;
   assign periphStop  = q.periphStop;

   // Cycles since last lock write and since oscillator restart
   logic [`SLVC_CNT_W-1:0] sinceLock;
   logic [`SLVC_CNT_W-1:0] sinceOsc;
   logic                   lockWr;
   logic                   oscWr;
   logic                   selClrWr;
   assign lockWr = q.dev.stb && q.dev.addr == `SLVC_DEV_PROT && q.dev.data == `SLVC_PROT_LOCK;
   assign oscWr = q.dev.stb && q.dev.addr == `SLVC_DEV_CLOCK && !q.dev.data[`SLVC_CLK_OSC_BIT]
                  && q.dev.data[`SLVC_CLK_SEL_BIT];
   assign selClrWr = q.dev.stb && q.dev.addr == `SLVC_DEV_CLOCK
                     && !q.dev.data[`SLVC_CLK_SEL_BIT];
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sinceLock <= '0;
         sinceOsc  <= '0;
      end else begin
         sinceLock <= lockWr ? '0 : (&sinceLock ? sinceLock : sinceLock + `SLVC_CNT_W'(1));
         sinceOsc  <= oscWr ? '0 : (&sinceOsc ? sinceOsc : sinceOsc + `SLVC_CNT_W'(1));
      end
   end

   sequence seqProtOpen;
      q.dev.stb && q.dev.addr == `SLVC_DEV_PROT && q.dev.data == `SLVC_PROT_ENABLE;
   endsequence
   sequence seqLevelWr;
      q.dev.stb && q.dev.addr == `SLVC_DEV_LEVEL;
   endsequence

   a_open_then_level: assert property (@(posedge clk) disable iff (!rst_b)
      seqProtOpen |=> seqLevelWr)
      else $error("level write did not follow protection opening");
   a_level_after_open: assert property (@(posedge clk) disable iff (!rst_b)
      seqLevelWr |-> $past(q.dev.stb) && $past(q.dev.addr) == `SLVC_DEV_PROT
                     && $past(q.dev.data) == `SLVC_PROT_ENABLE)
      else $error("level write without open protection");
   a_level_value_lock: assert property (@(posedge clk) disable iff (!rst_b)
      seqLevelWr |-> q.dev.data == `SLVC_LEVEL_SUB ##1 lockWr)
      else $error("level not 00h or not relocked");
   a_reg_wait_len: assert property (@(posedge clk) disable iff (!rst_b)
      (q.dev.stb && q.dev.addr == `SLVC_DEV_INTCTL && q.dev.data == q.intEn && q.done)
      |-> sinceLock >= `SLVC_CNT_W'(REG_WAIT_CYC))
      else $error("interrupts restored before regulator wait");
   a_osc_wait_len: assert property (@(posedge clk) disable iff (!rst_b)
      (selClrWr && $past(q.st, 2) == slvc_pkg::StOscWait)
      |-> sinceOsc >= `SLVC_CNT_W'(OSC_WAIT_CYC))
      else $error("select cleared before oscillator settled");
   a_divider_kept: assert property (@(posedge clk) disable iff (!rst_b)
      (q.dev.stb && q.dev.addr == `SLVC_DEV_CLOCK) |-> q.dev.data[2:0] == $past(q.clkShadow[2:0]))
      else $error("divider bits changed");
   a_sel_normal: assert property (@(posedge clk) disable iff (!rst_b)
      selClrWr |-> q.mode == slvc_pkg::ModeNormal && q.done)
      else $error("not normal after select cleared");
   a_extclk_off_lv: assert property (@(posedge clk) disable iff (!rst_b)
      q.mode == slvc_pkg::ModeLvSub |-> !q.serClkEn && q.periphStop)
      else $error("external clock enabled in low-voltage mode");
   a_reset_normal: assert property (@(posedge clk) disable iff (!rst_b)
      q.rstLvl |=> q.mode == slvc_pkg::ModeNormal && q.st == slvc_pkg::StIdle)
      else $error("not normal after device reset");
   a_read_wait: assert property (@(posedge clk) disable iff (!rst_b)
      (addrPh && !hwrite) |=> !q.rdy ##1 q.rdy)
      else $error("read wait state wrong");
endmodule : slvc_subclock_ctrl

/* File: slvc_consts.svh */
`ifndef SLVC_CONSTS_SVH
`define SLVC_CONSTS_SVH
// Controller register offsets (byte addresses)
`define SLVC_OFS_CTRL      8'h00
`define SLVC_OFS_STAT      8'h04
`define SLVC_OFS_CLK       8'h08
`define SLVC_OFS_INTEN     8'h0c
// Control and status fields
`define SLVC_CTRL_REL_LV   0
`define SLVC_CTRL_REL_SUB  1
`define SLVC_CTRL_MARK_LV  2
`define SLVC_STAT_DONE     0
// Device register targets on the write port
`define SLVC_DEV_AW        3
`define SLVC_DEV_INTCTL    3'h0
`define SLVC_DEV_PROT      3'h1
`define SLVC_DEV_LEVEL     3'h2
`define SLVC_DEV_CLOCK     3'h3
// Device data values
`define SLVC_PROT_ENABLE   8'hc9
`define SLVC_PROT_LOCK     8'h00
`define SLVC_LEVEL_SUB     8'h00
`define SLVC_INT_OFF       8'h00
`define SLVC_CLK_RESET     8'h00
`define SLVC_CLK_SEL_BIT   3
`define SLVC_CLK_OSC_BIT   6
// Timing
`define SLVC_CLK_HZ        10000000
`define SLVC_REG_WAIT_US   800
`define SLVC_REG_WAIT_CYC  (`SLVC_REG_WAIT_US * (`SLVC_CLK_HZ / 1000000))
`define SLVC_OSC_WAIT_CYC  2000
`define SLVC_CNT_W         16
`endif

/* File: slvc_pkg.sv */
`include "slvc_consts.svh"
package slvc_pkg;
   typedef enum logic [1:0] {ModeNormal, ModeSub, ModeLvSub} slvc_mode_t;

   typedef enum logic [3:0] {
      StIdle, StDisInt, StProtEn, StLevel, StProtOff, StRegWait,
      StRestore, StOscOn, StOscWait, StClrSel
   } slvc_state_t;

   typedef struct packed {
      logic                      stb;
      logic [`SLVC_DEV_AW-1:0]   addr;
      logic [7:0]                data;
   } slvc_dev_wr_t;

   typedef struct packed {
      slvc_state_t               st;
      slvc_mode_t                mode;
      logic [`SLVC_CNT_W-1:0]    cnt;
      slvc_dev_wr_t              dev;
      logic [7:0]                clkShadow;
      logic [7:0]                intEn;
      logic                      serClkEn;
      logic                      periphStop;
      logic                      done;
      logic                      rdy;
      logic [31:0]               rdata;
      logic                      wrPend;
      logic [7:0]                wrAddr;
      logic [2:0]                sync;
      logic                      rstLvl;
   } slvc_regs_t;
endpackage : slvc_pkg

/* File: slvc_dev_model.sv */
`timescale 1ns/1ps
`include "slvc_consts.svh"
module slvc_dev_model (
   input  wire logic             clk,
   input  wire logic             resetReq,
   input  slvc_pkg::slvc_dev_wr_t devWr,
   output logic                  devResetIn
);
   logic [7:0]  protQ;
   logic [7:0]  levelQ;
   logic [7:0]  clockQ;
   logic [7:0]  intQ;
   logic [10:0] logQ[$];
   assign devResetIn = resetReq;
   // Starts out in low-voltage subclock mode
   initial begin
      protQ = 8'h00;
      levelQ = 8'h02;
      clockQ = 8'h4b;
      intQ = 8'hff;
   end
   always @(posedge clk or posedge resetReq) begin
      if (resetReq) begin
         // reset returns to normal with protection, level and clock cleared; intQ keeps its value
         protQ <= `SLVC_PROT_LOCK;
         levelQ <= 8'h00;
         clockQ <= `SLVC_CLK_RESET;
      end else if (devWr.stb) begin
         logQ.push_back({devWr.addr, devWr.data});
         case (devWr.addr)
            `SLVC_DEV_PROT: protQ <= devWr.data;
            // level change only while protection is open
            `SLVC_DEV_LEVEL: if (protQ == `SLVC_PROT_ENABLE) levelQ <= devWr.data;
            // clearing the select bit returns to normal mode
            `SLVC_DEV_CLOCK: clockQ <= devWr.data;
            default: intQ <= devWr.data;
         endcase
      end
   end
endmodule : slvc_dev_model

/* File: subclock_low_voltage_mode_control_tb_top.sv */
`timescale 1ns/1ps
`include "slvc_consts.svh"
module subclock_low_voltage_mode_control_tb_top;
   typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d;} slvc_row_t;
   logic                   clk = 1'b0;
   logic                   rst_b = 1'b0;
   logic                   hsel = 1'b0;
   logic [31:0]            haddr = 32'h0;
   logic [1:0]             htrans = 2'b00;
   logic                   hwrite = 1'b0;
   logic [31:0]            hwdata = 32'h0;
   logic                   hreadyout;
   logic                   hresp;
   logic [31:0]            hrdata;
   logic                   resetReq = 1'b0;
   logic                   devResetIn;
   slvc_pkg::slvc_dev_wr_t devWr;
   logic                   serialClkEn;
   logic                   periphStop;
   logic [31:0]            r;
   int                     failures = 0;
   int                     cmp_count = 0;
   slvc_row_t              rows[8] = '{'{1'b1, 8'h0c, 32'h5a}, '{1'b0, 8'h0c, 32'h5a},
      '{1'b1, 8'h08, 32'h4b}, '{1'b0, 8'h08, 32'h4b}, '{1'b0, 8'h00, 32'h0},
      '{1'b1, 8'h40, 32'hff}, '{1'b0, 8'h40, 32'h0}, '{1'b0, 8'h04, 32'h0}};
   always #50 clk = ~clk;
   slvc_subclock_ctrl #(.REG_WAIT_CYC(20), .OSC_WAIT_CYC(10)) dut (
      .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .devResetIn(devResetIn),
      .devWr(devWr), .serialClkEn(serialClkEn), .periphStop(periphStop));
   slvc_dev_model mdl (.clk(clk), .resetReq(resetReq), .devWr(devWr),
      .devResetIn(devResetIn));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : ahb
   task automatic wait_done;
      for (int i = 0; i < 60; i++) begin
         ahb(1'b0, `SLVC_OFS_STAT, 32'h0);
         if (r[`SLVC_STAT_DONE] === 1'b1) break;
      end
   endtask : wait_done
   task automatic wait_log(input int n);
      for (int i = 0; i < 60 && mdl.logQ.size() < n; i++) @(posedge clk);
      chk("log size", n, mdl.logQ.size());
   endtask : wait_log
   task automatic give_verdict;
      $display("Comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   initial begin
      #3000000;
      failures++;
      give_verdict();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      foreach (rows[i]) begin
         ahb(rows[i].wr, rows[i].a, rows[i].d);
         if (!rows[i].wr) chk("row read", rows[i].d, r);
      end
      // Release while still normal is refused
      ahb(1'b1, `SLVC_OFS_CTRL, 32'h1);
      repeat (6) @(posedge clk);
      chk("refused log", 0, mdl.logQ.size());
      ahb(1'b1, `SLVC_OFS_CTRL, 32'h4);
      ahb(1'b0, `SLVC_OFS_STAT, 32'h0);
      chk("lv mode", 32'h8, r);
      chk("stop lv", 32'h1, {31'h0, periphStop});
      chk("serclk lv", 32'h0, {31'h0, serialClkEn});
      ahb(1'b1, `SLVC_OFS_CTRL, 32'h1);
      wait_log(4);
      chk("stop in wait", 32'h1, {31'h0, periphStop});
      chk("w0", {`SLVC_DEV_INTCTL, `SLVC_INT_OFF}, mdl.logQ[0]);
      chk("w1", {`SLVC_DEV_PROT, `SLVC_PROT_ENABLE}, mdl.logQ[1]);
      chk("w2", {`SLVC_DEV_LEVEL, `SLVC_LEVEL_SUB}, mdl.logQ[2]);
      chk("w3", {`SLVC_DEV_PROT, `SLVC_PROT_LOCK}, mdl.logQ[3]);
      wait_done();
      chk("level", 32'h0, mdl.levelQ);
      chk("w4", {`SLVC_DEV_INTCTL, 8'h5a}, mdl.logQ[4]);
      chk("stat sub", 32'h5, r & 32'h1f);
      chk("stop after", 32'h0, {31'h0, periphStop});
      chk("serclk after", 32'h1, {31'h0, serialClkEn});
      ahb(1'b1, `SLVC_OFS_STAT, 32'h1);
      ahb(1'b1, `SLVC_OFS_CTRL, 32'h2);
      wait_log(6);
      chk("osc on", {`SLVC_DEV_CLOCK, 8'h0b}, mdl.logQ[5]);
      wait_done();
      chk("sel clr", {`SLVC_DEV_CLOCK, 8'h03}, mdl.logQ[6]);
      chk("stat normal", 32'h1, r & 32'h1f);
      // Device reset forces normal mode and blocks commands
      ahb(1'b1, `SLVC_OFS_CTRL, 32'h4);
      resetReq <= 1'b1;
      repeat (6) @(posedge clk);
      ahb(1'b1, `SLVC_OFS_CTRL, 32'h4);
      ahb(1'b0, `SLVC_OFS_STAT, 32'h0);
      chk("reset mode", 32'h10, r & 32'h1c);
      chk("reset level", 32'h0, {16'h0, mdl.protQ, mdl.levelQ});
      rst_b <= 1'b0;
      resetReq <= 1'b0;
      repeat (2) @(posedge clk);
      chk("rst outs", 32'ha, {hreadyout, devWr.stb, serialClkEn, periphStop});
      give_verdict();
   end
endmodule : subclock_low_voltage_mode_control_tb_top
